// File: inc/xbar_defs.vh
// Constants for the priority crossbar: register offsets, fields, resets.
// Assumes 32-bit AXI4-Lite access, one register per aligned word.
`ifndef XBAR_DEFS_VH
`define XBAR_DEFS_VH

`define NPINS          25
`define PIN_UART_TX    5'd4
`define PIN_UART_RX    5'd5

// Register byte offsets
`define OFS_SEL0       8'h00
`define OFS_SEL1       8'h04
`define OFS_SEL2       8'h08
`define OFS_SKIP       8'h0c
`define OFS_INKIND     8'h10
`define OFS_OUTDRV     8'h14
`define OFS_LATCH      8'h18
`define OFS_PADS       8'h1c
`define OFS_MASK       8'h20
`define OFS_MATCH      8'h24
`define OFS_STATUS     8'h28
`define OFS_SPIMODE    8'h2c

// peripheral_select_0 fields
`define SEL0_UART      0
`define SEL0_SPI       2
`define SEL0_SMB       3
`define SEL0_CP0       4
`define SEL0_COMPARATOR_ZERO_ASYNC_OUT      5
`define SEL0_CP1       6
`define SEL0_COMPARATOR_ONE_ASYNC_OUT      7
// peripheral_select_1 fields
`define SEL1_SYSCK     1
`define SEL1_PCA_LO    2
`define SEL1_ECI       5
`define SEL1_T0        6
`define SEL1_T1        7
// peripheral_select_2 fields
`define SEL2_LIN       0
`define SEL2_XBE       6
`define SEL2_WPUD      7

// Slave select mode 4-wire codes have bit 1 set
`define SSMODE_4W_BIT  1

// Reset values
`define RST_SEL        8'h00
`define RST_SKIP       25'h0000000
`define RST_INKIND     25'h1ffffff
`define RST_OUTDRV     25'h0000000
`define RST_LATCH      25'h1ffffff
`define RST_MASK       25'h0000000
`define RST_MATCH      25'h1ffffff

// Signal slots in priority order
`define NSIG           23
`define SIG_UTX        0
`define SIG_URX        1
`define SIG_SCK        2
`define SIG_MISO       3
`define SIG_MOSI       4
`define SIG_NSS        5
`define SIG_SDA        6
`define SIG_SCL        7
`define SIG_CP0        8
`define SIG_COMPARATOR_ZERO_ASYNC_OUT       9
`define SIG_CP1        10
`define SIG_COMPARATOR_ONE_ASYNC_OUT       11
`define SIG_SYSCK      12
`define SIG_CEX0       13
`define SIG_ECI        19
`define SIG_T0         20
`define SIG_T1         21
`define SIG_LINTX      22
`define SIG_LINRX      23
`define NSIG_ALL       24

`endif

// File: design/pin_sync.v
// Two-flop synchroniser for a vector of pad inputs.
// Assumes pads are asynchronous to aclk.
`timescale 1ns/1ps
module pin_sync #(
    parameter W = 1
) (
    // Clock and reset
    input  wire         aclk,
    input  wire         aresetn,
    // Data
    input  wire [W-1:0] d,
    output reg  [W-1:0] q
);
    reg [W-1:0] meta_r;

    always @(posedge aclk) begin
        if (!aresetn) begin
            meta_r <= {W{1'b0}};
            q      <= {W{1'b0}};
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule

// File: design/pin_alloc.v
// Combinational priority decoder: UART TX/RX take fixed pins 4 and 5,
// each other requested signal the lowest free pin. Pure logic, no clock.
`timescale 1ns/1ps
`include "xbar_defs.vh"
module pin_alloc (
    // Requests and reservations
    input  wire [`NSIG_ALL-1:0] req,
    input  wire [`NPINS-1:0]    skip,
    // Result: per pin, owning signal index plus valid
    output reg  [`NPINS-1:0]    pin_used,
    output reg  [`NPINS*5-1:0]  pin_sig
);
    integer s;
    integer p;
    reg [`NPINS-1:0] taken;
    reg              placed;

    always @* begin
        pin_used = {`NPINS{1'b0}};
        pin_sig  = {`NPINS*5{1'b0}};
        taken    = skip;
        placed   = 1'b0;
        if (req[`SIG_UTX]) begin
            pin_used[`PIN_UART_TX] = 1'b1;
            pin_sig[`PIN_UART_TX*5 +: 5] = 5'd0;
            taken[`PIN_UART_TX] = 1'b1;
        end
        if (req[`SIG_URX]) begin
            pin_used[`PIN_UART_RX] = 1'b1;
            pin_sig[`PIN_UART_RX*5 +: 5] = 5'd1;
            taken[`PIN_UART_RX] = 1'b1;
        end
        for (s = 2; s < `NSIG_ALL; s = s + 1) begin
            placed = 1'b0;
            for (p = 0; p < `NPINS; p = p + 1) begin
                if (req[s] && !placed && !taken[p]) begin
                    taken[p]        = 1'b1;
                    pin_used[p]     = 1'b1;
                    pin_sig[p*5 +: 5] = s[4:0];
                    placed          = 1'b1;
                end
            end
            // no pin left, signal stays off
        end
    end
endmodule

// File: design/xbar_top.v
// Priority crossbar and port pin configuration with AXI4-Lite registers.
// Assumes pads use in/out/oe triples and peripherals share aclk.
//
// Design decisions made here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`include "xbar_defs.vh"
module xbar_top #(
    parameter NUSE = `NPINS
) (
    // Clock and reset
    input  wire                 aclk,
    input  wire                 aresetn,
    // AXI4-Lite write
    input  wire [7:0]           s_axi_awaddr,
    input  wire                 s_axi_awvalid,
    output reg                  s_axi_awready,
    input  wire [31:0]          s_axi_wdata,
    input  wire [3:0]           s_axi_wstrb,
    input  wire                 s_axi_wvalid,
    output reg                  s_axi_wready,
    output reg  [1:0]           s_axi_bresp,
    output reg                  s_axi_bvalid,
    input  wire                 s_axi_bready,
    // AXI4-Lite read
    input  wire [7:0]           s_axi_araddr,
    input  wire                 s_axi_arvalid,
    output reg                  s_axi_arready,
    output reg  [31:0]          s_axi_rdata,
    output reg  [1:0]           s_axi_rresp,
    output reg                  s_axi_rvalid,
    input  wire                 s_axi_rready,
    // Peripheral outputs toward pins
    input  wire [`NSIG_ALL-1:0] sig_out,
    input  wire [`NSIG_ALL-1:0] sig_oe,
    // Peripheral inputs from pins
    output reg  [`NSIG_ALL-1:0] sig_in,
    // Peripheral mode
    input  wire [1:0]           slave_select_mode,
    // Pads
    input  wire [`NPINS-1:0]    pad_in,
    output reg  [`NPINS-1:0]    pad_out,
    output reg  [`NPINS-1:0]    pad_oe,
    output reg  [`NPINS-1:0]    pad_pullup,
    output reg  [`NPINS-1:0]    pad_rx_en,
    // Port match event
    output reg                  match_event
);
    ////////////////////////////////////////////////////////////////////
    // Registers
    reg [7:0]         sel0_r;
    reg [7:0]         sel1_r;
    reg [7:0]         sel2_r;
    reg [`NPINS-1:0]  skip_r;
    reg [`NPINS-1:0]  inkind_r;
    reg [`NPINS-1:0]  outdrv_r;
    reg [`NPINS-1:0]  latch_r;
    reg [`NPINS-1:0]  mask_r;
    reg [`NPINS-1:0]  match_r;
    reg [1:0]         ssmode_r;

    wire [`NPINS-1:0] present = (NUSE >= `NPINS) ? {`NPINS{1'b1}} :
                                ({`NPINS{1'b1}} >> (`NPINS - NUSE));
    wire [`NPINS-1:0] pad_sync;

    pin_sync #(.W(`NPINS)) u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .d       (pad_in),
        .q       (pad_sync)
    );

    ////////////////////////////////////////////////////////////////////
    // Requests
    wire       xbe      = sel2_r[`SEL2_XBE];
    reg  [`NSIG_ALL-1:0] req;
    reg  [2:0] pca_n;
    integer    k;

    always @* begin
        req   = {`NSIG_ALL{1'b0}};
        pca_n = sel1_r[`SEL1_PCA_LO +: 3];
        req[`SIG_UTX]   = sel0_r[`SEL0_UART];
        req[`SIG_URX]   = sel0_r[`SEL0_UART];
        req[`SIG_SCK]   = sel0_r[`SEL0_SPI];
        req[`SIG_MISO]  = sel0_r[`SEL0_SPI];
        req[`SIG_MOSI]  = sel0_r[`SEL0_SPI];
        req[`SIG_NSS]   = sel0_r[`SEL0_SPI] & ssmode_r[`SSMODE_4W_BIT];
        req[`SIG_SDA]   = sel0_r[`SEL0_SMB];
        req[`SIG_SCL]   = sel0_r[`SEL0_SMB];
        req[`SIG_CP0]   = sel0_r[`SEL0_CP0];
        req[`SIG_COMPARATOR_ZERO_ASYNC_OUT]  = sel0_r[`SEL0_COMPARATOR_ZERO_ASYNC_OUT];
        req[`SIG_CP1]   = sel0_r[`SEL0_CP1];
        req[`SIG_COMPARATOR_ONE_ASYNC_OUT]  = sel0_r[`SEL0_COMPARATOR_ONE_ASYNC_OUT];
        req[`SIG_SYSCK] = sel1_r[`SEL1_SYSCK];
        for (k = 0; k < 6; k = k + 1) begin
            // Code 111 is reserved and routes nothing
            if (pca_n != 3'h7 && k < pca_n)
                req[`SIG_CEX0 + k] = 1'b1;
        end
        req[`SIG_ECI]   = sel1_r[`SEL1_ECI];
        req[`SIG_T0]    = sel1_r[`SEL1_T0];
        req[`SIG_T1]    = sel1_r[`SEL1_T1];
        req[`SIG_LINTX] = sel2_r[`SEL2_LIN];
        req[`SIG_LINRX] = sel2_r[`SEL2_LIN];
        if (!xbe)
            req = {`NSIG_ALL{1'b0}};
    end

    ////////////////////////////////////////////////////////////////////
    // Allocation
    wire [`NPINS-1:0]   pin_used;
    wire [`NPINS*5-1:0] pin_sig;

    pin_alloc u_alloc (
        .req      (req),
        .skip     (skip_r | ~present),
        .pin_used (pin_used),
        .pin_sig  (pin_sig)
    );

    ////////////////////////////////////////////////////////////////////
    // Pad drive
    reg [`NPINS-1:0]   out_nxt;
    reg [`NPINS-1:0]   oe_nxt;
    reg [`NPINS-1:0]   pu_nxt;
    reg [`NPINS-1:0]   rx_nxt;
    reg [`NSIG_ALL-1:0] in_nxt;
    reg [4:0]          idx;
    reg                val;
    reg                open_drain;
    integer            p;

    always @* begin
        out_nxt = {`NPINS{1'b0}};
        oe_nxt  = {`NPINS{1'b0}};
        pu_nxt  = {`NPINS{1'b0}};
        rx_nxt  = {`NPINS{1'b0}};
        in_nxt  = {`NSIG_ALL{1'b1}};
        idx     = 5'h00;
        val     = 1'b1;
        open_drain = 1'b0;
        for (p = 0; p < `NPINS; p = p + 1) begin
            idx = pin_sig[p*5 +: 5];
            if (pin_used[p]) begin
                val = sig_oe[idx] ? sig_out[idx] : 1'b1;
                in_nxt[idx] = pad_sync[p] & inkind_r[p];
            end else begin
                val = latch_r[p];
            end
            open_drain = !outdrv_r[p] ||
                (pin_used[p] && (idx == `SIG_SDA || idx == `SIG_SCL));
            // no drive while crossbar off, inputs
            if (xbe && present[p]) begin
                out_nxt[p] = val;
                oe_nxt[p]  = open_drain ? !val : 1'b1;
            end
            // pullup on open drain, off if low
            pu_nxt[p] = !sel2_r[`SEL2_WPUD] && open_drain &&
                        !(oe_nxt[p] && !out_nxt[p]);
            rx_nxt[p] = present[p];
            if (!inkind_r[p] || !present[p]) begin
                out_nxt[p] = 1'b0;
                oe_nxt[p]  = 1'b0;
                pu_nxt[p]  = 1'b0;
                rx_nxt[p]  = 1'b0;
            end
        end
    end

    // digital receive only when input kind is 1
    wire [`NPINS-1:0] pin_read = pad_sync & inkind_r & present;

    wire mism = |((pin_read ^ match_r) & mask_r & inkind_r & present);

    always @(posedge aclk) begin
        if (!aresetn) begin
            pad_out     <= {`NPINS{1'b0}};
            pad_oe      <= {`NPINS{1'b0}};
            pad_pullup  <= {`NPINS{1'b0}};
            pad_rx_en   <= {`NPINS{1'b0}};
            sig_in      <= {`NSIG_ALL{1'b1}};
            match_event <= 1'b0;
        end else begin
            pad_out     <= out_nxt;
            pad_oe      <= oe_nxt;
            pad_pullup  <= pu_nxt;
            pad_rx_en   <= rx_nxt;
            sig_in      <= in_nxt;
            match_event <= mism;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave
    reg        aw_hold_r;
    reg        w_hold_r;
    reg [7:0]  awaddr_r;
    reg [31:0] wdata_r;
    reg [3:0]  wstrb_r;
    wire       aw_ok = s_axi_awvalid & s_axi_awready;
    wire       w_ok  = s_axi_wvalid & s_axi_wready;
    wire       have_aw = aw_hold_r | aw_ok;
    wire       have_w  = w_hold_r | w_ok;
    wire [7:0]  wa  = aw_hold_r ? awaddr_r : s_axi_awaddr;
    wire [31:0] wd  = w_hold_r ? wdata_r : s_axi_wdata;
    wire [3:0]  ws  = w_hold_r ? wstrb_r : s_axi_wstrb;
    wire        do_wr = have_aw & have_w & !s_axi_bvalid;
    reg  [31:0] wmask;
    reg         wr_hit;
    reg  [31:0] wr_old;
    reg  [31:0] wr_new;

    always @* begin
        wmask = {{8{ws[3]}}, {8{ws[2]}}, {8{ws[1]}}, {8{ws[0]}}};
        wr_hit = 1'b1;
        case (wa)
            `OFS_SEL0:    wr_old = {24'h0, sel0_r};
            `OFS_SEL1:    wr_old = {24'h0, sel1_r};
            `OFS_SEL2:    wr_old = {24'h0, sel2_r};
            `OFS_SKIP:    wr_old = {7'h0, skip_r};
            `OFS_INKIND:  wr_old = {7'h0, inkind_r};
            `OFS_OUTDRV:  wr_old = {7'h0, outdrv_r};
            `OFS_LATCH:   wr_old = {7'h0, latch_r};
            `OFS_MASK:    wr_old = {7'h0, mask_r};
            `OFS_MATCH:   wr_old = {7'h0, match_r};
            `OFS_SPIMODE: wr_old = {30'h0, ssmode_r};
            default: begin
                wr_old = 32'h00000000;
                wr_hit = 1'b0;
            end
        endcase
        // Byte strobes keep unwritten bytes of the old word
        wr_new = (wr_old & ~wmask) | (wd & wmask);
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'h0;
            aw_hold_r     <= 1'b0;
            w_hold_r      <= 1'b0;
            awaddr_r      <= 8'h00;
            wdata_r       <= 32'h00000000;
            wstrb_r       <= 4'h0;
            sel0_r        <= `RST_SEL;
            sel1_r        <= `RST_SEL;
            sel2_r        <= `RST_SEL;
            skip_r        <= `RST_SKIP;
            inkind_r      <= `RST_INKIND;
            outdrv_r      <= `RST_OUTDRV;
            latch_r       <= `RST_LATCH;
            mask_r        <= `RST_MASK;
            match_r       <= `RST_MATCH;
            ssmode_r      <= 2'h0;
        end else begin
            if (aw_ok && !do_wr) begin
                aw_hold_r     <= 1'b1;
                awaddr_r      <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (w_ok && !do_wr) begin
                w_hold_r     <= 1'b1;
                wdata_r      <= s_axi_wdata;
                wstrb_r      <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (do_wr) begin
                aw_hold_r     <= 1'b0;
                w_hold_r      <= 1'b0;
                s_axi_awready <= 1'b0;
                s_axi_wready  <= 1'b0;
                s_axi_bvalid  <= 1'b1;
                s_axi_bresp   <= wr_hit ? 2'h0 : 2'h2;
                case (wa)
                    `OFS_SEL0:    sel0_r   <= wr_new[7:0] & 8'hfd;
                    `OFS_SEL1:    sel1_r   <= wr_new[7:0] & 8'hfe;
                    `OFS_SEL2:    sel2_r   <= wr_new[7:0] & 8'hc1;
                    `OFS_SKIP:    skip_r   <= wr_new[24:0];
                    `OFS_INKIND:  inkind_r <= wr_new[24:0];
                    `OFS_OUTDRV:  outdrv_r <= wr_new[24:0];
                    `OFS_LATCH:   latch_r  <= wr_new[24:0];
                    `OFS_MASK:    mask_r   <= wr_new[24:0];
                    `OFS_MATCH:   match_r  <= wr_new[24:0];
                    `OFS_SPIMODE: ssmode_r <= wr_new[1:0];
                    default: ;
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // Read path
    reg [31:0] rd_nxt;
    reg        rd_hit;

    always @* begin
        rd_hit = 1'b1;
        case (s_axi_araddr)
            `OFS_SEL0:    rd_nxt = {24'h0, sel0_r};
            `OFS_SEL1:    rd_nxt = {24'h0, sel1_r};
            `OFS_SEL2:    rd_nxt = {24'h0, sel2_r};
            `OFS_SKIP:    rd_nxt = {7'h0, skip_r};
            `OFS_INKIND:  rd_nxt = {7'h0, inkind_r};
            `OFS_OUTDRV:  rd_nxt = {7'h0, outdrv_r};
            `OFS_LATCH:   rd_nxt = {7'h0, latch_r};
            `OFS_PADS:    rd_nxt = {7'h0, pin_read};
            `OFS_MASK:    rd_nxt = {7'h0, mask_r};
            `OFS_MATCH:   rd_nxt = {7'h0, match_r};
            `OFS_STATUS:  rd_nxt = {6'h0, mism, pin_used};
            `OFS_SPIMODE: rd_nxt = {30'h0, ssmode_r};
            default: begin
                rd_nxt = 32'h00000000;
                rd_hit = 1'b0;
            end
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= 2'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_nxt;
            s_axi_rresp   <= rd_hit ? 2'h0 : 2'h2;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
endmodule

// File: testbench/pad_env.sv
// Board-side model of the port pads seen by the crossbar.
// Assumes pad_in feeds the chip's synchroniser directly.
`timescale 1ns/1ps
`include "xbar_defs.vh"
module pad_env (
    // Clock
    input  wire              aclk,
    // Chip side of each pad
    input  wire [`NPINS-1:0] pad_out,
    input  wire [`NPINS-1:0] pad_oe,
    input  wire [`NPINS-1:0] pad_pullup,
    // Board drivers
    input  wire [`NPINS-1:0] ext_en,
    input  wire [`NPINS-1:0] ext_val,
    // Resolved pad level
    output wire [`NPINS-1:0] pad_in
);
    logic [`NPINS-1:0] last_r = 25'h0;

    ////////////////////////////////////////////////////////////////////
    // A floating pad without pullup flips every cycle so a stale level is never read
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val)
                  | (~pad_oe & ~ext_en & (pad_pullup | ~last_r));

    always @(posedge aclk) begin
        last_r <= pad_in;
    end
endmodule

// File: testbench/xbar_top_chk.sv
// Checker for the crossbar top: bus answers and pad safety.
// Assumes one clock domain; bound onto every xbar_top.
`timescale 1ns/1ps
`include "xbar_defs.vh"
module xbar_top_chk #(
    parameter NUSE = `NPINS
) (
    // Clock and reset
    input wire                 aclk,
    input wire                 aresetn,
    // Bus handshakes
    input wire                 s_axi_awvalid,
    input wire                 s_axi_awready,
    input wire                 s_axi_wvalid,
    input wire                 s_axi_wready,
    input wire                 s_axi_bvalid,
    input wire                 s_axi_bready,
    input wire                 s_axi_arvalid,
    input wire                 s_axi_arready,
    input wire                 s_axi_rvalid,
    input wire                 s_axi_rready,
    // Pins and peripherals
    input wire [`NSIG_ALL-1:0] sig_in,
    input wire [`NPINS-1:0]    pad_out,
    input wire [`NPINS-1:0]    pad_oe,
    input wire [`NPINS-1:0]    pad_pullup,
    input wire [`NPINS-1:0]    pad_rx_en
);
    logic wr_seen_r;

    // Crossbar can only turn on through a completed write
    always @(posedge aclk) begin
        if (!aresetn) begin
            wr_seen_r <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            wr_seen_r <= 1'b1;
        end
    end

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    ////////////////////////////////////////////////////////////////////
    chk_wr_answer: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
        else $error("write answer not one cycle after capture");
    chk_rd_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer not one cycle after capture");
    chk_b_release: assert property (
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answer held after handshake");
    chk_r_release: assert property (
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer held after handshake");
    chk_pullup_low: assert property (
        (pad_pullup & pad_oe & ~pad_out) == 25'h0)
        else $error("pullup on while driving low");
    chk_analog_quiet: assert property (
        (~pad_rx_en & (pad_pullup | pad_oe)) == 25'h0)
        else $error("analog pin still pulled or driven");
    chk_idle_no_drive: assert property (
        !wr_seen_r |-> pad_oe == 25'h0)
        else $error("pad driven before crossbar enable");
    chk_idle_inputs: assert property (
        !wr_seen_r |-> &sig_in)
        else $error("peripheral input routed while crossbar off");
    chk_reset_digital: assert property (
        $past(aresetn) && !wr_seen_r |-> &pad_rx_en && &pad_pullup)
        else $error("pins not digital with pullups after reset");
endmodule

bind xbar_top xbar_top_chk #(.NUSE(NUSE)) chk_u (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .sig_in        (sig_in),
    .pad_out       (pad_out),
    .pad_oe        (pad_oe),
    .pad_pullup    (pad_pullup),
    .pad_rx_en     (pad_rx_en)
);

// File: testbench/test_priority_crossbar_port_assign.sv
// Self-checking bench: register bus, pin allocation, pad modes.
// Assumes xbar_top at full pin count beside the pad_env model.
`timescale 1ns/1ps
`include "xbar_defs.vh"
module test_priority_crossbar_port_assign;
    localparam TMO = 200;
    logic        aclk    = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  awaddr  = 8'h00;
    logic [7:0]  araddr  = 8'h00;
    logic [31:0] wdata   = 32'h0;
    logic        awvalid = 1'b0;
    logic        wvalid  = 1'b0;
    logic        bready  = 1'b0;
    logic        arvalid = 1'b0;
    logic        rready  = 1'b0;
    logic [23:0] sig_out = 24'h0;
    logic [23:0] sig_oe  = 24'h0;
    logic [24:0] ext_en  = 25'h0;
    logic [24:0] ext_val = 25'h0;
    wire         awready, wready, bvalid, arready, rvalid, match_event;
    wire  [1:0]  bresp, rresp;
    wire  [31:0] rdata;
    wire  [23:0] sig_in;
    wire  [24:0] pad_in, pad_out, pad_oe, pad_pu, pad_rx;
    int          err_count = 0;
    int          n_tests   = 0;
    logic [1:0]  wq[$];
    logic [65:0] rq[$];
    logic [65:0] e;
    logic [31:0] v;
    logic [7:0]  ofs[9] = '{`OFS_SEL0, `OFS_SEL1, `OFS_SEL2, `OFS_SKIP,
        `OFS_INKIND, `OFS_OUTDRV, `OFS_LATCH, `OFS_MASK, `OFS_MATCH};
    logic [31:0] rv[9] = '{`RST_SEL, `RST_SEL, `RST_SEL, `RST_SKIP,
        `RST_INKIND, `RST_OUTDRV, `RST_LATCH, `RST_MASK, `RST_MATCH};
    logic [31:0] sm[3] = '{32'h2, 32'h0, 32'h2};
    logic [31:0] s0[3] = '{32'h4, 32'h4, 32'h5};
    logic [31:0] ex[3] = '{32'h3d9, 32'h1d9, 32'h7f9};

    always #2.5 aclk = ~aclk;

    xbar_top dut_u (
        .aclk (aclk), .aresetn (aresetn),
        .s_axi_awaddr (awaddr), .s_axi_awvalid (awvalid),
        .s_axi_awready (awready), .s_axi_wdata (wdata),
        .s_axi_wstrb (4'hf), .s_axi_wvalid (wvalid),
        .s_axi_wready (wready), .s_axi_bresp (bresp),
        .s_axi_bvalid (bvalid), .s_axi_bready (bready),
        .s_axi_araddr (araddr), .s_axi_arvalid (arvalid),
        .s_axi_arready (arready), .s_axi_rdata (rdata),
        .s_axi_rresp (rresp), .s_axi_rvalid (rvalid),
        .s_axi_rready (rready), .sig_out (sig_out), .sig_oe (sig_oe),
        .sig_in (sig_in), .slave_select_mode (2'h0), .pad_in (pad_in),
        .pad_out (pad_out), .pad_oe (pad_oe), .pad_pullup (pad_pu),
        .pad_rx_en (pad_rx), .match_event (match_event)
    );

    pad_env pads_u (
        .aclk (aclk), .pad_out (pad_out), .pad_oe (pad_oe),
        .pad_pullup (pad_pu), .ext_en (ext_en), .ext_val (ext_val),
        .pad_in (pad_in)
    );

    ////////////////////////////////////////////////////////////////////
    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic settle;
        repeat (4) @(negedge aclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] r);
        int   n;
        logic pa, pw, pb;
        @(posedge aclk);
        wq.push_back(r);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        pa = 1'b1;
        pw = 1'b1;
        pb = 1'b1;
        for (n = 0; n < TMO && pb; n++) begin
            @(posedge aclk);
            if (pa && awready) begin
                awvalid <= 1'b0;
                pa = 1'b0;
            end
            if (pw && wready) begin
                wvalid <= 1'b0;
                pw = 1'b0;
            end
            if (bvalid) begin
                bready <= 1'b0;
                pb = 1'b0;
            end
        end
        if (pb) begin
            err_count++;
            tally_and_finish();
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] x,
                      input logic [31:0] m, input logic [1:0] r);
        int   n;
        logic pa, pb;
        @(posedge aclk);
        rq.push_back({r, m, x});
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        pa = 1'b1;
        pb = 1'b1;
        for (n = 0; n < TMO && pb; n++) begin
            @(posedge aclk);
            if (pa && arready) begin
                arvalid <= 1'b0;
                pa = 1'b0;
            end
            if (rvalid) begin
                rready <= 1'b0;
                pb = 1'b0;
            end
        end
        if (pb) begin
            err_count++;
            tally_and_finish();
        end
    endtask

    // Results are compared in the order their requests were issued
    always @(posedge aclk) begin
        if (bvalid && bready) begin
            check(bresp, wq.pop_front());
        end
        if (rvalid && rready) begin
            e = rq.pop_front();
            check({rresp, rdata & e[63:32]}, {e[65:64], e[31:0]});
        end
    end

    ////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(62942));
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        settle();
        check(pad_oe, 25'h0);
        check(pad_pu, 25'h1ffffff);
        check(pad_rx, 25'h1ffffff);
        check(sig_in, 24'hffffff);
        for (int i = 0; i < 9; i++) begin
            rd(ofs[i], rv[i], 32'hffffffff, 2'h0);
        end
        rd(8'h30, 32'h0, 32'hffffffff, 2'h2);
        wr(8'h30, 32'h5a, 2'h2);
        repeat (4) begin
            v = $urandom & 32'h1ffffff;
            sig_out <= v[23:0];
            wr(`OFS_MASK, v, 2'h0);
            rd(`OFS_MASK, v, 32'h1ffffff, 2'h0);
        end
        wr(`OFS_MASK, 32'h0, 2'h0);
        // skips and selections first, enable last
        wr(`OFS_SKIP, 32'h26, 2'h0);
        wr(`OFS_SEL1, 32'h0c, 2'h0);
        for (int k = 0; k < 3; k++) begin
            wr(`OFS_SEL2, 32'h0, 2'h0);
            wr(`OFS_SPIMODE, sm[k], 2'h0);
            wr(`OFS_SEL0, s0[k], 2'h0);
            wr(`OFS_SEL2, 32'h40, 2'h0);
            rd(`OFS_STATUS, ex[k], 32'h1ffffff, 2'h0);
        end
        // board pulls pin ten low, kept off the crossbar
        wr(`OFS_SEL2, 32'h0, 2'h0);
        wr(`OFS_OUTDRV, 32'h1fffbff, 2'h0);
        wr(`OFS_SKIP, 32'h1, 2'h0);
        wr(`OFS_SEL1, 32'h0, 2'h0);
        wr(`OFS_SEL0, 32'h8, 2'h0);
        sig_out <= 24'h40;
        sig_oe  <= 24'hc0;
        ext_en  <= 25'h400;
        wr(`OFS_SEL2, 32'h40, 2'h0);
        settle();
        rd(`OFS_STATUS, 32'h6, 32'h3ffffff, 2'h0);
        check(pad_oe[3:0], 4'hd);
        check(pad_pu[3:0], 4'h2);
        check(pad_out[2], 1'b0);
        check(sig_in, 24'hffff7f);
        wr(`OFS_SEL2, 32'hc0, 2'h0);
        settle();
        check(pad_pu[1], 1'b0);
        wr(`OFS_MASK, 32'h400, 2'h0);
        settle();
        check(match_event, 1'b1);
        rd(`OFS_STATUS, 32'h2000006, 32'h3ffffff, 2'h0);
        wr(`OFS_INKIND, 32'h1fffbf7, 2'h0);
        settle();
        check(match_event, 1'b0);
        check({pad_oe[3], pad_oe[10], pad_pu[10], pad_rx[10]}, 4'h0);
        rd(`OFS_PADS, 32'h0, 32'h408, 2'h0);
        wr(`OFS_SEL2, 32'h0, 2'h0);
        settle();
        check(pad_oe, 25'h0);
        check(sig_in, 24'hffffff);
        rd(`OFS_STATUS, 32'h0, 32'h1ffffff, 2'h0);
        settle();
        tally_and_finish();
    end
endmodule
